// File: shared/mcr_pkg.sv
/*
  Constants and types shared by the magnetometer control register block.
  Assumes the register addresses are byte offsets on the serial register port.
*/
`default_nettype none
package mcr_pkg;

  // ----------------------------------------
  // Register addresses and reset values.
  // ----------------------------------------
  localparam logic [7:0] MAG_CTRL_ONE_ADDR = 8'h5b;
  localparam logic [7:0] MAG_CTRL_TWO_ADDR = 8'h5c;
  localparam logic [7:0] MAG_CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] MAG_CTRL_TWO_RST  = 8'h00;

  // ----------------------------------------
  // Field positions of mag_control_one.
  // ----------------------------------------
  localparam int ONE_ACAL_BIT = 7;
  localparam int ONE_RST_BIT  = 6;
  localparam int ONE_OST_BIT  = 5;
  localparam int ONE_OS_MSB   = 4;
  localparam int ONE_OS_LSB   = 2;
  localparam int ONE_HMS_MSB  = 1;
  localparam int ONE_HMS_LSB  = 0;

  // ----------------------------------------
  // Field positions of mag_control_two.
  // ----------------------------------------
  localparam int TWO_HYB_BIT    = 5;
  localparam int TWO_MMDIS_BIT  = 4;
  localparam int TWO_MMTHS_BIT  = 3;
  localparam int TWO_MMRST_BIT  = 2;
  localparam int TWO_RSTCNT_MSB = 1;
  localparam int TWO_RSTCNT_LSB = 0;

  // ----------------------------------------
  // Field encodings.
  // ----------------------------------------
  localparam logic [1:0] HMS_ACCEL   = 2'h0;
  localparam logic [1:0] HMS_MAG     = 2'h1;
  localparam logic [1:0] HMS_HYBRID  = 2'h3;
  localparam logic [1:0] RSTCNT_EACH = 2'h0;
  localparam logic [1:0] RSTCNT_16   = 2'h1;
  localparam logic [1:0] RSTCNT_512  = 2'h2;
  localparam logic [1:0] RSTCNT_OFF  = 2'h3;

  // ----------------------------------------
  // Counts of output-data-rate cycles between automatic degauss.
  // ----------------------------------------
  localparam logic [9:0] DEG_PERIOD_16  = 10'h010;
  localparam logic [9:0] DEG_PERIOD_512 = 10'h200;

  // ----------------------------------------
  // Burst-read addresses and output windows.
  // ----------------------------------------
  localparam logic [7:0] ACCEL_Z_HIGH_ADDR        = 8'h05;
  localparam logic [7:0] ACCEL_Z_LOW_ADDR         = 8'h06;
  localparam logic [7:0] MAG_OUT_FIRST_ADDR       = 8'h33;
  localparam logic [7:0] MAG_OUT_LAST_ADDR        = 8'h38;
  localparam logic [7:0] SYNCED_ACCEL_X_HIGH_ADDR = 8'h39;
  localparam logic [7:0] SYNCED_ACCEL_LAST_ADDR   = 8'h3e;

  // ----------------------------------------
  // Min/max tracking reset values.
  // ----------------------------------------
  localparam logic [15:0] MIN_RESET_VAL = 16'h7fff;
  localparam logic [15:0] MAX_RESET_VAL = 16'h8000;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h1,
    MS_RUN  = 2'h2
  } mcr_meas_t;

endpackage
`default_nettype wire

// File: rtl/mcr_minmax.sv
/*
  Per-axis min/max tracking memory and hard-iron offset registers.
  Assumes one sample set per output-data-rate cycle and a one-cycle clear request.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_minmax import mcr_pkg::*; #(
  parameter int DW = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 sampleValid,
  input  wire logic signed [DW-1:0] sampleX,
  input  wire logic signed [DW-1:0] sampleY,
  input  wire logic signed [DW-1:0] sampleZ,
  input  wire logic                 trackEn,
  input  wire logic                 clearReq,
  input  wire logic                 odrTick,
  input  wire logic                 acalEn,
  output logic signed [DW-1:0]      offX_r,
  output logic signed [DW-1:0]      offY_r,
  output logic signed [DW-1:0]      offZ_r
);

  logic signed [DW-1:0] max_r [3];
  logic signed [DW-1:0] min_r [3];
  logic signed [DW-1:0] off_r [3];
  logic signed [DW-1:0] max_nxt [3];
  logic signed [DW-1:0] min_nxt [3];
  logic signed [DW-1:0] off_nxt [3];
  logic signed [DW-1:0] smp [3];

  assign smp[0] = sampleX;
  assign smp[1] = sampleY;
  assign smp[2] = sampleZ;

  function automatic logic signed [DW-1:0] midPoint(input logic signed [DW-1:0] a,
                                                   input logic signed [DW-1:0] b);
    logic signed [DW:0] sum;
    sum = {a[DW-1], a} + {b[DW-1], b};
    return sum[DW:1];
  endfunction

  // ----------------------------------------
  // Next-state of tracking and offsets.
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      max_nxt[i] = max_r[i];
      min_nxt[i] = min_r[i];
      off_nxt[i] = off_r[i];
      if (clearReq) begin
        max_nxt[i] = MAX_RESET_VAL[DW-1:0];
        min_nxt[i] = MIN_RESET_VAL[DW-1:0];
      end else if (sampleValid && trackEn) begin
        if (smp[i] > max_r[i]) max_nxt[i] = smp[i];
        if (smp[i] < min_r[i]) min_nxt[i] = smp[i];
      end
      if (odrTick && acalEn) begin
        off_nxt[i] = midPoint(max_r[i], min_r[i]);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        max_r[i] <= '0;
        min_r[i] <= '0;
        off_r[i] <= '0;
      end
    end else begin
      max_r <= max_nxt;
      min_r <= min_nxt;
      off_r <= off_nxt;
    end
  end

  assign offX_r = off_r[0];
  assign offY_r = off_r[1];
  assign offZ_r = off_r[2];

  a_minmax_clear_values: assert property (@(posedge mclk) disable iff (!nrst)
    clearReq |=> (min_r[1] == MIN_RESET_VAL[DW-1:0]) && (max_r[2] == MAX_RESET_VAL[DW-1:0]))
    else $error("Min/max clear did not load full-scale values.");

  a_acal_offset_load: assert property (@(posedge mclk) disable iff (!nrst)
    (odrTick && acalEn) |=>
      (2 * int'(off_r[0]) - (int'($past(max_r[0])) + int'($past(min_r[0])))) inside {0, -1})
    else $error("Offset is not the midpoint of max and min.");

endmodule
`default_nettype wire

// File: rtl/mcr_sched.sv
/*
  Magnetic degauss scheduler: periodic, standby-to-active and manual resets.
  Assumes the sensor reports the end of each reset with a one-cycle done pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_sched import mcr_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       odrStart,
  input  wire logic [1:0] rstCnt,
  input  wire logic       goActive,
  input  wire logic       manualReq,
  input  wire logic       degaussDone,
  output logic            degaussStart_r
);

  logic [9:0] cycCnt_r, cycCnt_nxt;
  logic       busy_r, busy_nxt;
  logic       start_nxt;
  logic       autoDue;
  logic [9:0] period;

  // ----------------------------------------
  // Period select and request arbitration.
  // ----------------------------------------
  always_comb begin
    period = (rstCnt == RSTCNT_512) ? DEG_PERIOD_512 : DEG_PERIOD_16;
    autoDue = odrStart && (rstCnt != RSTCNT_OFF) &&
              ((rstCnt == RSTCNT_EACH) || (cycCnt_r == 10'h000));
    cycCnt_nxt = cycCnt_r;
    if (rstCnt == RSTCNT_EACH || rstCnt == RSTCNT_OFF) begin
      cycCnt_nxt = 10'h000;
    end else if (odrStart) begin
      cycCnt_nxt = (cycCnt_r + 10'h001 >= period) ? 10'h000 : cycCnt_r + 10'h001;
    end
    start_nxt = !busy_r && (autoDue || goActive || manualReq);
    busy_nxt = busy_r;
    if (start_nxt) begin
      busy_nxt = 1'b1;
    end else if (degaussDone) begin
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cycCnt_r       <= 10'h000;
      busy_r         <= 1'b0;
      degaussStart_r <= 1'b0;
    end else begin
      cycCnt_r       <= cycCnt_nxt;
      busy_r         <= busy_nxt;
      degaussStart_r <= start_nxt;
    end
  end

  a_degauss_each_cycle: assert property (@(posedge mclk) disable iff (!nrst)
    (odrStart && rstCnt == RSTCNT_EACH && !busy_r) |=> degaussStart_r)
    else $error("No degauss at the start of an output-data-rate cycle.");

  a_degauss_on_active: assert property (@(posedge mclk) disable iff (!nrst)
    (goActive && !busy_r) |=> degaussStart_r ##1 !degaussStart_r)
    else $error("No single degauss on entering Active.");

  a_degauss_disabled: assert property (@(posedge mclk) disable iff (!nrst)
    (rstCnt == RSTCNT_OFF && !goActive && !manualReq) |=> !degaussStart_r)
    else $error("Automatic degauss fired while disabled.");

endmodule
`default_nettype wire

// File: rtl/mcr_top.sv
/*
  Magnetometer control registers with trigger, tracking, degauss and burst logic.
  Assumes the serial interface gives synchronous register strobes and burst steps.
*/
// What this block does
// - With auto-calibration on, each axis offset loads (max+min)/2 at every ODR cycle end.
// - Writing one to the degauss bit starts one sensor reset if none is running; the bit clears at the next reset completion.
// - A one-shot measure set in Standby takes one measurement then clears; in Active it is ignored.
// - The oversample field with the system rate sets the magnetic output update rate.
// - Sensor select 00 runs the accelerometer, 01 the magnetometer and 11 both.
// - In hybrid mode each sensor runs at half the selected system rate.
// - In hybrid mode magnetic data sits at 0x33-0x38 and synced accel data at 0x39-0x3E.
// - With hybrid wrap on and fast read off, a burst jumps to 0x33 after reading 0x06.
// - With hybrid wrap on and fast read on, a burst jumps to 0x33 after reading 0x05.
// - Min/max tracking runs each ODR cycle while its disable bit is zero and stops when one.
// - With the threshold-disable bit set, tracking stops once a threshold event fires.
// - Writing one to min/max reset loads min 0x7FFF and max 0x8000, then self-clears.
// - The degauss field schedules resets every cycle, every 16, every 512 or never.
// - With automatic degauss off, resets still occur on Standby-to-Active and manual request.
// - Offsets are applied to magnetic data only while raw mode is zero.
`timescale 1ns/10ps
`default_nettype none
module mcr_top import mcr_pkg::*; #(
  parameter int DW = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic [7:0]           regAddr,
  input  wire logic                 regWrEn,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regRdEn,
  output logic [7:0]                regRdData_r,
  input  wire logic                 burstStep,
  input  wire logic [7:0]           burstAddr,
  input  wire logic                 fastRead,
  output logic [7:0]                nextAddr_r,
  input  wire logic                 isActive,
  input  wire logic                 systemTick,
  input  wire logic                 rawMode,
  input  wire logic                 thsEvent,
  input  wire logic                 degaussDone,
  input  wire logic                 measureDone,
  input  wire logic                 magSampleValid,
  input  wire logic signed [DW-1:0] magSampleX,
  input  wire logic signed [DW-1:0] magSampleY,
  input  wire logic signed [DW-1:0] magSampleZ,
  output logic                      accelEnable_r,
  output logic                      magEnable_r,
  output logic [2:0]                osrSelect_r,
  output logic                      hybridMap_r,
  output logic                      sensorTick_r,
  output logic                      degaussStart_r,
  output logic                      measureStart_r,
  output logic                      magValid_r,
  output logic signed [DW-1:0]      magX_r,
  output logic signed [DW-1:0]      magY_r,
  output logic signed [DW-1:0]      magZ_r
);

  logic [7:0]           ctrlOne_r, ctrlOne_nxt;
  logic [7:0]           ctrlTwo_r, ctrlTwo_nxt;
  mcr_meas_t            measState_r, measState_nxt;
  logic                 thsStop_r, thsStop_nxt;
  logic                 halfPhase_r, halfPhase_nxt;
  logic                 wasActive_r;
  logic                 accelEnable_nxt, magEnable_nxt, hybridMap_nxt;
  logic [2:0]           osrSelect_nxt;
  logic                 sensorTick_nxt, measureStart_nxt, magValid_nxt;
  logic [7:0]           nextAddr_nxt, regRdData_nxt;
  logic signed [DW-1:0] magX_nxt, magY_nxt, magZ_nxt;
  logic signed [DW-1:0] offX, offY, offZ;
  logic                 wrOne, wrTwo, hybridNow, odrTick;
  logic [1:0]           hmsNow;

  assign wrOne     = regWrEn && (regAddr == MAG_CTRL_ONE_ADDR);
  assign wrTwo     = regWrEn && (regAddr == MAG_CTRL_TWO_ADDR);
  assign hmsNow    = ctrlOne_r[ONE_HMS_MSB:ONE_HMS_LSB];
  assign hybridNow = (hmsNow == HMS_HYBRID);
  assign odrTick   = sensorTick_r && magEnable_r;

  // ----------------------------------------
  // Control registers and trigger sequencing.
  // ----------------------------------------
  always_comb begin
    ctrlOne_nxt      = ctrlOne_r;
    ctrlTwo_nxt      = ctrlTwo_r;
    measState_nxt    = measState_r;
    measureStart_nxt = 1'b0;
    if (wrOne) begin
      ctrlOne_nxt[ONE_ACAL_BIT]            = regWrData[ONE_ACAL_BIT];
      ctrlOne_nxt[ONE_OS_MSB:ONE_OS_LSB]   = regWrData[ONE_OS_MSB:ONE_OS_LSB];
      ctrlOne_nxt[ONE_HMS_MSB:ONE_HMS_LSB] = regWrData[ONE_HMS_MSB:ONE_HMS_LSB];
    end
    if (degaussDone) begin
      ctrlOne_nxt[ONE_RST_BIT] = 1'b0;
    end
    if (wrOne && regWrData[ONE_RST_BIT]) begin
      ctrlOne_nxt[ONE_RST_BIT] = 1'b1;
    end
    case (measState_r)
      MS_IDLE: begin
        if (wrOne && regWrData[ONE_OST_BIT] && !isActive) begin
          ctrlOne_nxt[ONE_OST_BIT] = 1'b1;
          measureStart_nxt         = 1'b1;
          measState_nxt            = MS_RUN;
        end
      end
      MS_RUN: begin
        if (measureDone) begin
          ctrlOne_nxt[ONE_OST_BIT] = 1'b0;
          measState_nxt            = MS_IDLE;
        end
      end
      default: begin
        ctrlOne_nxt[ONE_OST_BIT] = 1'b0;
        measState_nxt            = MS_IDLE;
      end
    endcase
    ctrlTwo_nxt[TWO_MMRST_BIT] = 1'b0;
    if (wrTwo) begin
      ctrlTwo_nxt[TWO_HYB_BIT:TWO_MMTHS_BIT]       = regWrData[TWO_HYB_BIT:TWO_MMTHS_BIT];
      ctrlTwo_nxt[TWO_MMRST_BIT]                   = regWrData[TWO_MMRST_BIT];
      ctrlTwo_nxt[TWO_RSTCNT_MSB:TWO_RSTCNT_LSB]   = regWrData[TWO_RSTCNT_MSB:TWO_RSTCNT_LSB];
    end
    thsStop_nxt = thsStop_r;
    if (!ctrlTwo_r[TWO_MMTHS_BIT] || ctrlTwo_r[TWO_MMRST_BIT]) begin
      thsStop_nxt = 1'b0;
    end else if (thsEvent) begin
      thsStop_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // Sensor enables, rate halving and data path.
  // ----------------------------------------
  always_comb begin
    accelEnable_nxt = (hmsNow != HMS_MAG);
    magEnable_nxt   = hmsNow[0];
    hybridMap_nxt   = hybridNow;
    osrSelect_nxt   = ctrlOne_r[ONE_OS_MSB:ONE_OS_LSB];
    halfPhase_nxt   = halfPhase_r;
    if (systemTick) begin
      halfPhase_nxt = hybridNow ? !halfPhase_r : 1'b0;
    end
    sensorTick_nxt = systemTick && (!hybridNow || halfPhase_r);
    magValid_nxt   = magSampleValid;
    magX_nxt       = magX_r;
    magY_nxt       = magY_r;
    magZ_nxt       = magZ_r;
    if (magSampleValid) begin
      magX_nxt = rawMode ? magSampleX : magSampleX - offX;
      magY_nxt = rawMode ? magSampleY : magSampleY - offY;
      magZ_nxt = rawMode ? magSampleZ : magSampleZ - offZ;
    end
  end

  // ----------------------------------------
  // Burst address advance and register read.
  // ----------------------------------------
  always_comb begin
    nextAddr_nxt = nextAddr_r;
    if (burstStep) begin
      if (ctrlTwo_r[TWO_HYB_BIT] && fastRead && burstAddr == ACCEL_Z_HIGH_ADDR) begin
        nextAddr_nxt = MAG_OUT_FIRST_ADDR;
      end else if (ctrlTwo_r[TWO_HYB_BIT] && !fastRead && burstAddr == ACCEL_Z_LOW_ADDR) begin
        nextAddr_nxt = MAG_OUT_FIRST_ADDR;
      end else begin
        nextAddr_nxt = burstAddr + 8'h01;
      end
    end
    regRdData_nxt = regRdData_r;
    if (regRdEn) begin
      if (regAddr == MAG_CTRL_ONE_ADDR) begin
        regRdData_nxt = ctrlOne_r;
      end else if (regAddr == MAG_CTRL_TWO_ADDR) begin
        regRdData_nxt = ctrlTwo_r;
      end else begin
        regRdData_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrlOne_r      <= MAG_CTRL_ONE_RST;
      ctrlTwo_r      <= MAG_CTRL_TWO_RST;
      measState_r    <= MS_IDLE;
      thsStop_r      <= 1'b0;
      halfPhase_r    <= 1'b0;
      wasActive_r    <= 1'b0;
      accelEnable_r  <= 1'b0;
      magEnable_r    <= 1'b0;
      hybridMap_r    <= 1'b0;
      osrSelect_r    <= 3'h0;
      sensorTick_r   <= 1'b0;
      measureStart_r <= 1'b0;
      magValid_r     <= 1'b0;
      magX_r         <= '0;
      magY_r         <= '0;
      magZ_r         <= '0;
      nextAddr_r     <= 8'h00;
      regRdData_r    <= 8'h00;
    end else begin
      ctrlOne_r      <= ctrlOne_nxt;
      ctrlTwo_r      <= ctrlTwo_nxt;
      measState_r    <= measState_nxt;
      thsStop_r      <= thsStop_nxt;
      halfPhase_r    <= halfPhase_nxt;
      wasActive_r    <= isActive;
      accelEnable_r  <= accelEnable_nxt;
      magEnable_r    <= magEnable_nxt;
      hybridMap_r    <= hybridMap_nxt;
      osrSelect_r    <= osrSelect_nxt;
      sensorTick_r   <= sensorTick_nxt;
      measureStart_r <= measureStart_nxt;
      magValid_r     <= magValid_nxt;
      magX_r         <= magX_nxt;
      magY_r         <= magY_nxt;
      magZ_r         <= magZ_nxt;
      nextAddr_r     <= nextAddr_nxt;
      regRdData_r    <= regRdData_nxt;
    end
  end

  // ----------------------------------------
  // Submodules.
  // ----------------------------------------
  mcr_minmax #(.DW(DW)) uMinmax (
    .mclk        (mclk),
    .nrst        (nrst),
    .sampleValid (magSampleValid),
    .sampleX     (magSampleX),
    .sampleY     (magSampleY),
    .sampleZ     (magSampleZ),
    .trackEn     (!ctrlTwo_r[TWO_MMDIS_BIT] && !thsStop_r),
    .clearReq    (ctrlTwo_r[TWO_MMRST_BIT]),
    .odrTick     (odrTick),
    .acalEn      (ctrlOne_r[ONE_ACAL_BIT]),
    .offX_r      (offX),
    .offY_r      (offY),
    .offZ_r      (offZ)
  );

  mcr_sched uSched (
    .mclk           (mclk),
    .nrst           (nrst),
    .odrStart       (odrTick),
    .rstCnt         (ctrlTwo_r[TWO_RSTCNT_MSB:TWO_RSTCNT_LSB]),
    .goActive       (isActive && !wasActive_r),
    .manualReq      (wrOne && regWrData[ONE_RST_BIT]),
    .degaussDone    (degaussDone),
    .degaussStart_r (degaussStart_r)
  );

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  a_burst_wrap_slow: assert property (@(posedge mclk) disable iff (!nrst)
    (burstStep && ctrlTwo_r[TWO_HYB_BIT] && !fastRead && burstAddr == ACCEL_Z_LOW_ADDR)
      |=> nextAddr_r == MAG_OUT_FIRST_ADDR)
    else $error("Burst did not wrap to magnetic output after Z low.");

  a_burst_wrap_fast: assert property (@(posedge mclk) disable iff (!nrst)
    (burstStep && ctrlTwo_r[TWO_HYB_BIT] && fastRead && burstAddr == ACCEL_Z_HIGH_ADDR)
      |=> nextAddr_r == MAG_OUT_FIRST_ADDR)
    else $error("Fast burst did not wrap to magnetic output after Z high.");

  a_ost_active_ignored: assert property (@(posedge mclk) disable iff (!nrst)
    (measState_r == MS_IDLE && wrOne && regWrData[ONE_OST_BIT] && isActive)
      |=> !ctrlOne_r[ONE_OST_BIT] && !measureStart_r)
    else $error("One-shot measure acted while Active.");

  a_ost_standby_run: assert property (@(posedge mclk) disable iff (!nrst)
    (measState_r == MS_IDLE && wrOne && regWrData[ONE_OST_BIT] && !isActive)
      |=> measureStart_r && ctrlOne_r[ONE_OST_BIT] ##1 !measureStart_r)
    else $error("One-shot measure did not start once in Standby.");

  a_rst_held_busy: assert property (@(posedge mclk) disable iff (!nrst)
    (ctrlOne_r[ONE_RST_BIT] && !degaussDone) |=> ctrlOne_r[ONE_RST_BIT])
    else $error("Degauss bit cleared before the reset finished.");

  a_rst_done_clear: assert property (@(posedge mclk) disable iff (!nrst)
    (degaussDone && !(wrOne && regWrData[ONE_RST_BIT])) |=> !ctrlOne_r[ONE_RST_BIT])
    else $error("Degauss bit not cleared on completion.");

  a_maxmin_rst_self: assert property (@(posedge mclk) disable iff (!nrst)
    (ctrlTwo_r[TWO_MMRST_BIT] && !wrTwo) |=> !ctrlTwo_r[TWO_MMRST_BIT])
    else $error("Min/max reset bit did not self-clear.");

  a_hms_decode: assert property (@(posedge mclk) disable iff (!nrst)
    (hmsNow == HMS_MAG) ##1 (hmsNow == HMS_MAG) |-> magEnable_r && !accelEnable_r)
    else $error("Sensor select 01 did not give magnetometer only.");

  a_hybrid_half_rate: assert property (@(posedge mclk) disable iff (!nrst)
    (hybridNow && systemTick) ##1 (hybridNow && systemTick)
      |=> !(sensorTick_r && $past(sensorTick_r)))
    else $error("Hybrid mode passed two system ticks in a row.");

  a_raw_bypass: assert property (@(posedge mclk) disable iff (!nrst)
    (magSampleValid && rawMode) |=> magX_r == $past(magSampleX))
    else $error("Offset applied in raw mode.");

  a_osr_follows: assert property (@(posedge mclk) disable iff (!nrst)
    wrOne ##1 !wrOne |=> osrSelect_r == $past(regWrData[ONE_OS_MSB:ONE_OS_LSB], 2))
    else $error("Oversample output does not follow the written field.");

endmodule
`default_nettype wire

// File: tb/mcr_sensor_model.sv
/*
  Sensor stand-in: ends each degauss and measurement after a fixed delay.
  Assumes one-cycle start pulses on the rising edge of mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_sensor_model #(
  parameter int DLY = 8
) (
  input  wire logic mclk,
  input  wire logic degaussStart_r,
  input  wire logic measureStart_r,
  output logic      degaussDone,
  output logic      measureDone
);
  initial begin
    degaussDone = 1'b0;
    measureDone = 1'b0;
  end
  always @(posedge mclk) begin
    if (degaussStart_r) begin
      repeat (DLY) @(posedge mclk);
      degaussDone <= 1'b1;
      @(posedge mclk);
      degaussDone <= 1'b0;
    end
  end
  always @(posedge mclk) begin
    if (measureStart_r) begin
      repeat (DLY) @(posedge mclk);
      measureDone <= 1'b1;
      @(posedge mclk);
      measureDone <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/mcr_top_tb.sv
/*
  Self-checking bench for the magnetometer control registers.
  Assumes mcr_pkg, the design and the sensor model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_top_tb import mcr_pkg::*; ;
  logic mclk, nrst, regWrEn, regRdEn, burstStep, fastRead, isActive, systemTick;
  logic rawMode, thsEvent, magSampleValid, degaussDone, measureDone, accelEnable_r;
  logic magEnable_r, hybridMap_r, sensorTick_r, degaussStart_r, measureStart_r, magValid_r;
  logic        [7:0]  regAddr, regWrData, burstAddr, regRdData_r, nextAddr_r;
  logic        [2:0]  osrSelect_r;
  logic signed [15:0] magSampleX, magSampleY, magSampleZ, magX_r, magY_r, magZ_r;
  logic        [1:0]  hmsTab [3] = '{HMS_ACCEL, HMS_MAG, HMS_HYBRID};
  int n_mismatch = 0, n_checks = 0, cyc = 0, nTick = 0;

  mcr_top #(.DW(16)) i_dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .burstStep(burstStep), .burstAddr(burstAddr), .fastRead(fastRead),
    .nextAddr_r(nextAddr_r), .isActive(isActive), .systemTick(systemTick),
    .rawMode(rawMode), .thsEvent(thsEvent), .degaussDone(degaussDone),
    .measureDone(measureDone), .magSampleValid(magSampleValid), .magSampleX(magSampleX),
    .magSampleY(magSampleY), .magSampleZ(magSampleZ), .accelEnable_r(accelEnable_r),
    .magEnable_r(magEnable_r), .osrSelect_r(osrSelect_r), .hybridMap_r(hybridMap_r),
    .sensorTick_r(sensorTick_r), .degaussStart_r(degaussStart_r),
    .measureStart_r(measureStart_r), .magValid_r(magValid_r), .magX_r(magX_r),
    .magY_r(magY_r), .magZ_r(magZ_r));
  mcr_sensor_model #(.DLY(8)) i_sensor (.mclk(mclk), .degaussStart_r(degaussStart_r),
    .measureStart_r(measureStart_r), .degaussDone(degaussDone), .measureDone(measureDone));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (sensorTick_r === 1'b1) nTick++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1 chk({8'h00, regRdData_r}, {8'h00, e});
  endtask
  task automatic burst(input logic [7:0] a, input logic f, input logic [7:0] e);
    @(posedge mclk);
    burstAddr <= a; fastRead <= f; burstStep <= 1'b1;
    @(posedge mclk);
    burstStep <= 1'b0;
    #1 chk({8'h00, nextAddr_r}, {8'h00, e});
  endtask
  task automatic sysTick;
    @(posedge mclk);
    systemTick <= 1'b1;
    @(posedge mclk);
    systemTick <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic magSmp(input logic r, input logic [15:0] x, input logic [15:0] e);
    @(posedge mclk);
    rawMode <= r; magSampleX <= x; magSampleValid <= 1'b1;
    @(posedge mclk);
    magSampleValid <= 1'b0;
    #1 chk(16'(magValid_r), 16'h0001);
    chk(magX_r, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {nrst, regWrEn, regRdEn, burstStep, fastRead, isActive, systemTick} = '0;
    {rawMode, thsEvent, magSampleValid, regAddr, regWrData, burstAddr} = '0;
    {magSampleX, magSampleY, magSampleZ} = '0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(MAG_CTRL_ONE_ADDR, 8'h00); rd(MAG_CTRL_TWO_ADDR, 8'h00); rd(8'h10, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      wr(MAG_CTRL_ONE_ADDR, {6'h07, hmsTab[i]});
      rd(MAG_CTRL_ONE_ADDR, {6'h07, hmsTab[i]});
      chk(16'(accelEnable_r), 16'(hmsTab[i] != HMS_MAG));
      chk(16'(magEnable_r), 16'(hmsTab[i] != HMS_ACCEL));
      chk(16'(hybridMap_r), 16'(hmsTab[i] == HMS_HYBRID));
      chk(16'(osrSelect_r), 16'h0007);
    end
    nTick = 0; sysTick(); sysTick();
    chk(16'(nTick), 16'h0001);
    $display("mode test done");
    wr(MAG_CTRL_ONE_ADDR, 8'h01); repeat (20) @(posedge mclk);
    wr(MAG_CTRL_ONE_ADDR, 8'h41); rd(MAG_CTRL_ONE_ADDR, 8'h41);
    repeat (20) @(posedge mclk);
    rd(MAG_CTRL_ONE_ADDR, 8'h01);
    wr(MAG_CTRL_ONE_ADDR, 8'h21);
    #1 chk(16'(measureStart_r), 16'h0001);
    rd(MAG_CTRL_ONE_ADDR, 8'h21); repeat (20) @(posedge mclk);
    rd(MAG_CTRL_ONE_ADDR, 8'h01);
    @(posedge mclk);
    isActive <= 1'b1; repeat (20) @(posedge mclk);
    wr(MAG_CTRL_ONE_ADDR, 8'h21); rd(MAG_CTRL_ONE_ADDR, 8'h01);
    $display("trigger test done");
    wr(MAG_CTRL_TWO_ADDR, 8'h04); rd(MAG_CTRL_TWO_ADDR, 8'h00);
    wr(MAG_CTRL_TWO_ADDR, 8'h20); rd(MAG_CTRL_TWO_ADDR, 8'h20);
    burst(8'h06, 1'b0, 8'h33); burst(8'h05, 1'b1, 8'h33);
    burst(8'h05, 1'b0, 8'h06); burst(8'h06, 1'b1, 8'h07);
    $display("burst test done");
    magSmp(1'b1, 16'h1234, 16'h1234);
    wr(MAG_CTRL_ONE_ADDR, 8'h81);
    sysTick();
    magSmp(1'b0, 16'h2000, 16'h0dcc);
    magSmp(1'b1, 16'h2000, 16'h2000);
    wr(MAG_CTRL_TWO_ADDR, 8'h2b);
    @(posedge mclk);
    thsEvent <= 1'b1;
    @(posedge mclk);
    thsEvent <= 1'b0;
    magSmp(1'b1, 16'h3000, 16'h3000);
    sysTick();
    magSmp(1'b0, 16'h3000, 16'h16e6);
    $display("data test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
